// ### verilog/atsc_defs.vh
/*
 * constants of the attenuator serial control block: word layout,
 * register offsets, reset values and link timing figures.
 * assumes inclusion by bare name from the block's design files.
 */
`ifndef ATSC_DEFS_VH
`define ATSC_DEFS_VH

// serial word layout, msb first
`define ATSC_WORD_W            6
`define ATSC_GUARD_BIT_POS     5
`define ATSC_TOP_WEIGHT_BIT_POS 4
`define ATSC_BOTTOM_WEIGHT_BIT_POS 0
`define ATSC_STEP_W            5

// apb register offsets (byte addresses)
`define ATSC_OFS_CTRL          12'h000
`define ATSC_OFS_STATUS        12'h004
`define ATSC_OFS_SHIFT         12'h008
`define ATSC_OFS_STEP          12'h00C

// control register fields
`define ATSC_CTRL_LINK_EN      0
`define ATSC_CTRL_REJECT_GUARD 1
`define ATSC_CTRL_RESET        32'h0000_0001
`define ATSC_LINK_EN_RST       1'b1
`define ATSC_REJECT_GUARD_RST  1'b0

// status register fields
`define ATSC_STAT_GUARD_ERR    0
`define ATSC_STAT_OVERRUN      1
`define ATSC_STAT_LINK_CLK     2
`define ATSC_STAT_STROBE       3
`define ATSC_STAT_EARLY        4

// power-up load length and the bit count that marks an overrun
`define ATSC_PU_LOAD_LAST      2'h3
`define ATSC_OVERRUN_AT        3'h6

// link timing, in ns, and derived 50 MHz cycle counts
`define ATSC_CLK_PERIOD_NS     20
`define ATSC_MIN_LINK_HALF_NS  30
`define ATSC_MIN_LINK_HALF_CYC ((`ATSC_MIN_LINK_HALF_NS + `ATSC_CLK_PERIOD_NS - 1) / `ATSC_CLK_PERIOD_NS)

`endif

// ### verilog/atsc_sync.v
/*
 * two-flop synchroniser for one level from outside the clock domain.
 * assumes clk runs the receiving domain; only the second flop is read.
 */
`timescale 1ns/100ps
module atsc_sync
(
   input  wire clk,      // receiving clock
   input  wire resetn,   // async reset, active low
   input  wire ce,       // clock enable
   input  wire din,      // asynchronous level
   output reg  dout_q    // synchronised level
);
   reg meta_q;

   // first flop feeds only the second
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         meta_q <= 1'b0;
         dout_q <= 1'b0;
      end
      else if (ce)
      begin
         meta_q <= din;
         dout_q <= meta_q;
      end
   end
endmodule

// ### verilog/atsc_edge.v
/*
 * rise and fall detector on an already synchronised level.
 * assumes the input is in the clk domain.
 */
`timescale 1ns/100ps
module atsc_edge
(
   input  wire clk,      // clock
   input  wire resetn,   // async reset, active low
   input  wire ce,       // clock enable
   input  wire lvl,      // synchronised level
   output wire rise,     // one-cycle pulse on rising edge
   output wire fall      // one-cycle pulse on falling edge
);
   reg prev_q;

   // delayed copy for edge compare
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         prev_q <= 1'b0;
      else if (ce)
         prev_q <= lvl;
   end

   assign rise = lvl & ~prev_q;
   assign fall = ~lvl & prev_q;
endmodule

// ### verilog/atsc_top.v
/*
 * serial control port of a five-bit step attenuator: link shift register,
 * word strobe latch, parallel power-up load, and an apb register view.
 * assumes serial_clk, serial_data, word_strobe and the step_ctl pins come
 * from outside the clk domain; the apb master is on clk.
 */
`timescale 1ns/100ps
`include "atsc_defs.vh"

// Overview of operation
// - six-bit word shifted in msb first, guard bit first, weight bit 0 last
// - word bit 4 drives 8 dB step, bit 0 the 0.5 dB step
// - at power-up step bits load from the five parallel step pins
// - any of the 32 combinations may be chosen as power-up state
// - data sampled on shift clock rise, held through following fall
// - strobe high makes latch transparent; strobe low holds value
// - shifting proceeds whatever the strobe level
// - five step bits are binary weighted, all ones is full attenuation
module atsc_top
(
   input  wire        clk,               // 50 MHz system clock
   input  wire        resetn,            // async reset, active low
   input  wire        ce,                // clock enable, freezes state when low
   input  wire        serial_clk,        // link shift clock
   input  wire        serial_data,       // link serial data
   input  wire        word_strobe,       // latch strobe, high is transparent
   input  wire        step_ctl_8db,      // parallel power-up 8 dB
   input  wire        step_ctl_4db,      // parallel power-up 4 dB
   input  wire        step_ctl_2db,      // parallel power-up 2 dB
   input  wire        step_ctl_1db,      // parallel power-up 1 dB
   input  wire        step_ctl_half_db,  // parallel power-up 0.5 dB
   input  wire        psel,              // apb select
   input  wire        penable,           // apb enable
   input  wire        pwrite,            // apb write
   input  wire [11:0] paddr,             // apb byte address
   input  wire [31:0] pwdata,            // apb write data
   output reg  [31:0] prdata,            // apb read data
   output reg         pready,            // apb ready
   output reg         pslverr,           // apb error
   output reg  [4:0]  atten_q            // step controls, bit 4 is 8 dB
);
   // synchronised link and pin levels
   wire       sclk_s;
   wire       sdata_s;
   wire       strobe_s;
   wire [4:0] pins_s;
   wire [4:0] pins_raw;
   wire       sclk_rise;
   wire       sclk_fall;

   assign pins_raw = {step_ctl_8db, step_ctl_4db, step_ctl_2db,
                      step_ctl_1db, step_ctl_half_db};

   atsc_sync u_sync_clk
   (
      .clk    (clk),
      .resetn (resetn),
      .ce     (ce),
      .din    (serial_clk),
      .dout_q (sclk_s)
   );

   atsc_sync u_sync_data
   (
      .clk    (clk),
      .resetn (resetn),
      .ce     (ce),
      .din    (serial_data),
      .dout_q (sdata_s)
   );

   atsc_sync u_sync_strobe
   (
      .clk    (clk),
      .resetn (resetn),
      .ce     (ce),
      .din    (word_strobe),
      .dout_q (strobe_s)
   );

   // one synchroniser per parallel step pin
   genvar gi;
   generate
      for (gi = 0; gi < `ATSC_STEP_W; gi = gi + 1)
      begin : g_pin
         atsc_sync u_sync_pin
         (
            .clk    (clk),
            .resetn (resetn),
            .ce     (ce),
            .din    (pins_raw[gi]),
            .dout_q (pins_s[gi])
         );
      end
   endgenerate

   atsc_edge u_edge_clk
   (
      .clk    (clk),
      .resetn (resetn),
      .ce     (ce),
      .lvl    (sclk_s),
      .rise   (sclk_rise),
      .fall   (sclk_fall)
   );

   // data synchroniser matches the clock's, so the sampled bit lines up
   // with the rise as seen here; host hold past the fall covers skew
   reg  [5:0] shift_q;
   reg  [2:0] bit_cnt_q;
   reg        overrun_q;
   reg        guard_err_q;
   reg        powerup_q;
   reg  [1:0] pu_wait_q;
   reg        link_en_q;
   reg        reject_guard_q;
   reg  [2:0] fall_seen_q;
   reg        strobe_early_q;

   // shift on every link rise while link_en_q is set, strobe level ignored
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         shift_q   <= 6'h00;
         bit_cnt_q <= 3'h0;
      end
      else if (ce && link_en_q && sclk_rise)
      begin
         shift_q   <= {shift_q[4:0], sdata_s};
         if (bit_cnt_q != 3'd7)
            bit_cnt_q <= bit_cnt_q + 3'd1;
      end
      else if (ce && strobe_s)
         bit_cnt_q <= 3'h0;
   end

   // counts clk cycles since the last link fall, saturating
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         fall_seen_q <= 3'h7;
      else if (ce)
      begin
         if (sclk_fall)
            fall_seen_q <= 3'h0;
         else if (fall_seen_q != 3'h7)
            fall_seen_q <= fall_seen_q + 3'd1;
      end
   end

   // power-up: pins settle through the synchronisers, then load once
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         powerup_q <= 1'b1;
         pu_wait_q <= 2'h0;
      end
      else if (ce && powerup_q)
      begin
         if (pu_wait_q == `ATSC_PU_LOAD_LAST)
            powerup_q <= 1'b0;
         else
            pu_wait_q <= pu_wait_q + 2'd1;
      end
   end

   // output latch: parallel load once, then transparent while strobe high
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         atten_q <= 5'h00;
      else if (ce)
      begin
         if (powerup_q)
            atten_q <= pins_s;
         else if (strobe_s && !(reject_guard_q && shift_q[`ATSC_GUARD_BIT_POS]))
            atten_q <= shift_q[`ATSC_TOP_WEIGHT_BIT_POS:`ATSC_BOTTOM_WEIGHT_BIT_POS];
      end
   end

   // apb decode; a write counts once, at the edge that samples pready high,
   // so a master that holds its request one cycle longer never writes twice
   wire        apb_acc   = psel && penable;
   wire        apb_take  = apb_acc && pready;
   wire        apb_wr    = apb_take && pwrite;
   wire        addr_ok   = (paddr == `ATSC_OFS_CTRL) || (paddr == `ATSC_OFS_STATUS) ||
                           (paddr == `ATSC_OFS_SHIFT) || (paddr == `ATSC_OFS_STEP);
   wire        wr_ctrl   = apb_wr && (paddr == `ATSC_OFS_CTRL);
   wire        wr_stat   = apb_wr && (paddr == `ATSC_OFS_STATUS);
   wire        clr_guard = wr_stat && pwdata[`ATSC_STAT_GUARD_ERR];
   wire        clr_over  = wr_stat && pwdata[`ATSC_STAT_OVERRUN];
   wire        clr_early = wr_stat && pwdata[`ATSC_STAT_EARLY];
   wire        start_acc = apb_acc && !pready;
   reg  [31:0] rdata_d;
   reg  [31:0] status_d;
   reg  [31:0] ctrl_d;

   // strobe seen with the link clock high, or right after its fall;
   // a gap shorter than one clk period cannot be resolved here, so this
   // only catches gross ordering faults of the host
   wire        early_now = strobe_s && (sclk_s || fall_seen_q == 3'h0);

   // guard flag: a strobe that would apply a word with the guard bit high;
   // set wins over a same-cycle software clear, so no event is lost
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         guard_err_q <= 1'b0;
      else if (ce)
      begin
         if (strobe_s && shift_q[`ATSC_GUARD_BIT_POS] && !powerup_q)
            guard_err_q <= 1'b1;
         else if (clr_guard)
            guard_err_q <= 1'b0;
      end
   end

   // overrun flag: a seventh accepted rise before a strobe reset the count;
   // ignored shifts with the link off do not count
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         overrun_q <= 1'b0;
      else if (ce)
      begin
         if (link_en_q && sclk_rise && bit_cnt_q >= `ATSC_OVERRUN_AT)
            overrun_q <= 1'b1;
         else if (clr_over)
            overrun_q <= 1'b0;
      end
   end

   // early strobe flag, set wins as above
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         strobe_early_q <= 1'b0;
      else if (ce)
      begin
         if (early_now)
            strobe_early_q <= 1'b1;
         else if (clr_early)
            strobe_early_q <= 1'b0;
      end
   end

   // status word from the field positions, so the map lives in one place
   always @*
   begin
      status_d                       = 32'h0000_0000;
      status_d[`ATSC_STAT_GUARD_ERR] = guard_err_q;
      status_d[`ATSC_STAT_OVERRUN]   = overrun_q;
      status_d[`ATSC_STAT_LINK_CLK]  = sclk_s;
      status_d[`ATSC_STAT_STROBE]    = strobe_s;
      status_d[`ATSC_STAT_EARLY]     = strobe_early_q;
   end

   // control word, unused bits read zero
   always @*
   begin
      ctrl_d                            = 32'h0000_0000;
      ctrl_d[`ATSC_CTRL_LINK_EN]        = link_en_q;
      ctrl_d[`ATSC_CTRL_REJECT_GUARD]   = reject_guard_q;
   end

   // read mux, unmapped reads zero; the level bits of status are the
   // synchronised copies, so they lag the pins by two cycles
   always @*
   begin
      rdata_d = 32'h0000_0000;
      case (paddr)
         `ATSC_OFS_CTRL:   rdata_d = ctrl_d;
         `ATSC_OFS_STATUS: rdata_d = status_d;
         `ATSC_OFS_SHIFT:  rdata_d = {26'h0, shift_q};
         `ATSC_OFS_STEP:   rdata_d = {27'h0, atten_q};
         default:          rdata_d = 32'h0000_0000;
      endcase
   end

   // control register; link on and guard check off out of reset, so a host
   // that never touches the bus still programs the steps
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         link_en_q      <= `ATSC_LINK_EN_RST;
         reject_guard_q <= `ATSC_REJECT_GUARD_RST;
      end
      else if (ce && wr_ctrl)
      begin
         link_en_q      <= pwdata[`ATSC_CTRL_LINK_EN];
         reject_guard_q <= pwdata[`ATSC_CTRL_REJECT_GUARD];
      end
   end

   // bus answer: pready registered so every output comes from a flop, at
   // the cost of one wait state; read data is captured with it and holds
   // until the next access
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
      else if (ce)
      begin
         pready  <= start_acc;
         pslverr <= start_acc && !addr_ok;
         if (start_acc)
            prdata <= rdata_d;
      end
   end
endmodule

// ### testbench/atsc_top_sva.sv
/* port checker for atsc_top: apb answer shape, power-up load, latch hold.
   assumes one clk domain and resetn async active low. */
`timescale 1ns/100ps
module atsc_top_sva
(
   input wire        clk,              // clock
   input wire        resetn,           // reset
   input wire        psel,             // apb
   input wire        penable,          // apb
   input wire        pwrite,           // apb
   input wire [11:0] paddr,            // apb
   input wire [31:0] prdata,           // apb
   input wire        pready,           // apb
   input wire        pslverr,          // apb
   input wire        word_strobe,      // strobe
   input wire        step_ctl_8db,     // pin
   input wire        step_ctl_4db,     // pin
   input wire        step_ctl_2db,     // pin
   input wire        step_ctl_1db,     // pin
   input wire        step_ctl_half_db, // pin
   input wire [4:0]  atten_q           // steps
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // pins gathered in step order, 8 dB on top
   wire [4:0] pins = {step_ctl_8db, step_ctl_4db, step_ctl_2db, step_ctl_1db, step_ctl_half_db};

   rdy_pulse_a: assert property (pready |=> !pready) else $error("pready held");
   rdy_cause_a: assert property (pready |-> $past(psel && penable)) else $error("stray pready");
   err_ready_a: assert property (pslverr |-> pready) else $error("pslverr alone");
   bad_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   good_addr_a: assert property (pready && paddr[11:4] == 8'h00 && paddr[1:0] == 2'b00
      |-> !pslverr) else $error("mapped address refused");
   step_read_a: assert property (pready && !pwrite && paddr == 12'h00C
      |-> prdata == {27'h000_0000, atten_q}) else $error("step read wrong");
   shift_read_a: assert property (pready && !pwrite && paddr == 12'h008
      |-> prdata[31:6] == 26'h000_0000) else $error("shift read too wide");
   powerup_a: assert property ($rose(resetn) |-> ##6 atten_q == pins)
      else $error("power-up load wrong");
   latch_hold_a: assert property (!word_strobe [*6] |-> $stable(atten_q))
      else $error("steps moved while latched");

   cover property ($rose(word_strobe));
   cover property (pready && pslverr);
   cover property ($rose(resetn));
endmodule

bind atsc_top atsc_top_sva u_sva (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .prdata,
   .pready, .pslverr, .word_strobe, .step_ctl_8db, .step_ctl_4db, .step_ctl_2db,
   .step_ctl_1db, .step_ctl_half_db, .atten_q);

// ### testbench/atsc_host_model.sv
/* host controller model: shifts link words and pulses the strobe.
   assumes the bench calls one task at a time and shares its clk. */
`timescale 1ns/100ps
module atsc_host_model
(
   input  logic clk,         // bench clock, pins move right after its rise
   output logic serial_clk,  // shift clock
   output logic serial_data, // serial data
   output logic word_strobe  // latch strobe
);
   // shift clock and strobe idle low, data high, clock still between frames
   initial
   begin
      serial_clk = 1'b0;
      serial_data = 1'b1;
      word_strobe = 1'b0;
   end
   // msb first, 160 ns period, 40 ns lead and hold
   task shift(input logic [7:0] w, input int n);
      @(posedge clk);
      for (int i = n - 1; i >= 0; i--)
      begin
         serial_data <= w[i];
         repeat (2) @(posedge clk);
         serial_clk <= 1'b1;
         repeat (4) @(posedge clk);
         serial_clk <= 1'b0;
         repeat (2) @(posedge clk);
      end
      serial_data <= ~serial_data;   // released line never shows stale data
   endtask
   // gap after last fall, pulse wide enough for clk
   task pulse;
      @(posedge clk);
      word_strobe <= 1'b1;
      repeat (10) @(posedge clk);
      word_strobe <= 1'b0;
      repeat (5) @(posedge clk);
   endtask
   task set_strobe(input logic v);
      word_strobe <= v;
   endtask
   // guard bit always sent low
   task word(input logic [4:0] s);
      shift({3'b000, s}, 6);
      pulse;
   endtask
endmodule

// ### testbench/atsc_top_tb.sv
/* bench for atsc_top: power-up loads, link words, apb reads.
   assumes the host model drives the link pins. */
`timescale 1ns/100ps
module atsc_top_tb;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic        ce = 1'b1;
   logic [4:0]  pins = 5'h00;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'hFFFF_FFFF;
   logic [31:0] rd;
   logic        er;
   wire  [31:0] prdata;
   wire  [4:0]  atten_q;
   wire         pready, pslverr, serial_clk, serial_data, word_strobe;
   int          errors = 0;
   int          n_compared = 0;

   // 50 MHz clock
   always #10 clk = ~clk;

   atsc_host_model host (.clk, .serial_clk, .serial_data, .word_strobe);
   atsc_top dut (.clk, .resetn, .ce, .serial_clk, .serial_data, .word_strobe,
      .step_ctl_8db(pins[4]), .step_ctl_4db(pins[3]), .step_ctl_2db(pins[2]),
      .step_ctl_1db(pins[1]), .step_ctl_half_db(pins[0]), .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .atten_q);

   task end_sim;
      if (errors == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_compared++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   // one apb transfer, held until pready
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (pready !== 1'b1 && k < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 20)
      begin
         errors++;
         $display("ERROR %0t apb timeout", $time);
         end_sim;
      end
   endtask

   task do_reset;
      resetn <= 1'b0;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      repeat (8) @(posedge clk);
   endtask

   // every pin pattern is taken at power-up
   task t_powerup;
      for (int p = 0; p < 32; p++)
      begin
         pins <= p[4:0];
         do_reset;
         chk(atten_q, p, "power-up");
      end
   endtask

   // single steps, full scale, reference
   task t_words;
      logic [4:0] s [5] = '{5'h10, 5'h01, 5'h08, 5'h1F, 5'h00};
      foreach (s[i])
      begin
         host.word(s[i]);
         chk(atten_q, s[i], "word");
         apb(1'b0, 12'h00C, 32'h0000_0000);
         chk(rd, s[i], "step read");
      end
   endtask

   // shifting under a low strobe must not move the steps
   task t_hold;
      host.shift(8'h05, 6);
      repeat (4) @(posedge clk);
      chk(atten_q, 5'h00, "hold");
      host.pulse;
      chk(atten_q, 5'h05, "strobe");
   endtask

   // eight bits sent, only the newest six kept
   task t_overrun;
      host.shift(8'hD3, 8);
      host.pulse;
      chk(atten_q, 5'h13, "overrun");
      apb(1'b0, 12'h008, 32'h0000_0000);
      chk(rd, 32'h0000_0013, "shift read");
      apb(1'b0, 12'h004, 32'h0000_0000);
      chk(rd, 32'h0000_0002, "overrun flag");
      apb(1'b1, 12'h004, 32'h0000_0002);
      apb(1'b0, 12'h004, 32'h0000_0000);
      chk(rd, 32'h0000_0000, "overrun clear");
   endtask

   // strobe held high while shifting
   task t_open;
      host.set_strobe(1'b1);
      host.shift(8'h0A, 6);
      repeat (6) @(posedge clk);
      chk(atten_q, 5'h0A, "transparent");
      host.set_strobe(1'b0);
      apb(1'b0, 12'h004, 32'h0000_0000);
      chk(rd, 32'h0000_0011, "guard and early flags");
      apb(1'b1, 12'h004, 32'h0000_0013);
   endtask

   // link off ignores words; guard rejection keeps the old steps
   task t_ctrl;
      apb(1'b1, 12'h000, 32'h0000_0000);
      apb(1'b0, 12'h000, 32'h0000_0000);
      chk(rd, 32'h0000_0000, "ctrl read");
      host.word(5'h07);
      chk(atten_q, 5'h0A, "link off");
      apb(1'b1, 12'h000, 32'h0000_0003);
      host.shift(8'h25, 6);
      host.pulse;
      chk(atten_q, 5'h0A, "guard refused");
      apb(1'b1, 12'h000, 32'h0000_0001);
      host.word(5'h15);
      chk(atten_q, 5'h15, "link on");
   endtask

   // clock enable low freezes the link side and the steps
   task t_freeze;
      @(posedge clk);
      ce <= 1'b0;
      host.word(5'h03);
      chk(atten_q, 5'h15, "frozen");
      ce <= 1'b1;
      repeat (4) @(posedge clk);
      chk(atten_q, 5'h15, "thawed");
   endtask

   // unmapped place refuses writes and reads zero
   task t_unmapped;
      apb(1'b1, 12'h010, 32'hFFFF_FFFF);
      chk(er, 1'b1, "write err");
      apb(1'b0, 12'h010, 32'h0000_0000);
      chk(er, 1'b1, "read err");
      chk(rd, 32'h0000_0000, "read zero");
   endtask

   initial
   begin
      do_reset;
      t_powerup;
      t_words;
      t_hold;
      t_overrun;
      t_open;
      t_ctrl;
      t_freeze;
      t_unmapped;
      end_sim;
   end
endmodule
